// ===== multi_phy_receive_read_port_tb_top.sv
// Bench joining both ends of the receive read port over one interface.
// Assumes the host makes the link clock from clk and the FIFOs hold 32 words.
`timescale 1ns/1ps
`include "rx_port_defs.svh"

module multi_phy_receive_read_port_tb_top;
	// ================================================================
	// Stimulus, results and bookkeeping
	logic clk, nrst, in_valid, in_sop, in_eop, req_valid, user_stall;
	rx_port_pkg::xfer_mode_e mode;
	logic [1:0] in_chan;
	logic [15:0] in_data;
	logic [4:0] req_chan;
	logic in_ready, req_ready, word_valid, word_sop, avail_polled;
	logic [15:0] word_data;
	logic [3:0] avail_direct;
	logic [15:0] got_d[$]; // Words seen by the user side
	logic got_s[$];
	int err_total, tests_run, cycles;

	// ================================================================
	// Both ends and the checker
	rx_port_if link_if ();
	rx_port_device rx_port_device_inst (.clk(clk), .nrst(nrst), .mode(mode), .in_valid(in_valid),
		.in_ready(in_ready), .in_chan(in_chan), .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop), .link(link_if));
	rx_port_host rx_port_host_inst (.clk(clk), .nrst(nrst), .mode(mode), .req_valid(req_valid),
		.req_ready(req_ready), .req_chan(req_chan), .user_stall(user_stall), .word_valid(word_valid),
		.word_data(word_data), .word_sop(word_sop), .avail_polled(avail_polled), .avail_direct(avail_direct),
		.link(link_if));
	rx_port_chk rx_port_chk_inst (.clk(clk), .nrst(nrst), .mode(mode), .link_clk(link_if.link_clk),
		.rd_enb_n(link_if.rd_enb_n), .rd_addr(link_if.rd_addr), .rx_data(link_if.rx_data),
		.rx_data_oe(link_if.rx_data_oe), .rx_start_of_packet(link_if.rx_start_of_packet),
		.rx_sop_oe(link_if.rx_sop_oe), .rx_data_valid(link_if.rx_data_valid), .rx_valid_oe(link_if.rx_valid_oe),
		.rx_packet_available_polled(link_if.rx_packet_available_polled),
		.rx_packet_available_direct(link_if.rx_packet_available_direct));

	// ================================================================
	// Clock and hang guard; the whole run needs just over a thousand cycles
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			end_of_test();
		end
	end

	// ================================================================
	// Compare and report
	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ================================================================
	// Drivers: all inputs move 1 ns after a rising edge
	task automatic do_reset(input rx_port_pkg::xfer_mode_e m);
		// Mode only changes under reset, as it must stay fixed in operation
		@(posedge clk);
		#1 nrst = 0;
		mode = m;
		repeat (5) @(posedge clk);
		#1 nrst = 1;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic push_pkt(input logic [1:0] ch, input logic [15:0] base, input int len);
		int n;
		for (int i = 0; i < len; i++) begin
			// Word held until an edge sees the FIFO ready
			in_valid = 1;
			in_chan = ch;
			in_data = base + 16'(i);
			in_sop = (i == 0);
			in_eop = (i == len - 1);
			n = 0;
			while (in_ready !== 1'b1 && n < 200) begin
				@(posedge clk);
				#1 n++;
			end
			chk1("source ready", 1'b1, in_ready);
			@(posedge clk);
			#1;
		end
		in_valid = 0;
	endtask
	task automatic read_chan(input logic [4:0] ch, input int stall_at);
		int n, st;
		got_d.delete();
		got_s.delete();
		req_chan = ch;
		req_valid = 1;
		n = 0;
		// Request stays up until the host leaves idle
		while (req_ready !== 1'b0 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		chk1("request taken", 1'b0, req_ready);
		req_valid = 0;
		n = 0;
		st = 0;
		while (req_ready !== 1'b1 && n < 3000) begin
			if (word_valid === 1'b1) begin
				got_d.push_back(word_data);
				got_s.push_back(word_sop);
			end
			// Pause the reader for a while once stall_at words are in
			user_stall = (got_d.size() >= stall_at && st < 60);
			if (user_stall)
				st++;
			@(posedge clk);
			#1 n++;
		end
		user_stall = 0;
		chk1("read ended", 1'b1, req_ready);
	endtask
	task automatic check_words(input logic [15:0] base, input int len, input logic sop);
		chk16("word count", 16'(len), 16'(got_d.size()));
		for (int i = 0; i < len && i < got_d.size(); i++) begin
			chk16("word data", base + 16'(i), got_d[i]);
			if (sop)
				chk1("word start flag", i == 0, got_s[i]);
		end
	endtask

	// ================================================================
	// Scenarios
	task automatic t_packet();
		do_reset(rx_port_pkg::MODE_PACKET);
		push_pkt(2'h2, 16'h2000, 3);
		push_pkt(2'h1, 16'h1000, 2);
		read_chan(5'h02, 99);
		check_words(16'h2000, 3, 1);
		read_chan(5'h01, 99);
		check_words(16'h1000, 2, 1);
	endtask
	task automatic t_foreign();
		read_chan(5'h05, 99);
		chk16("foreign words", 16'h0000, 16'(got_d.size()));
		read_chan(5'h1f, 99);
		chk16("null words", 16'h0000, 16'(got_d.size()));
	endtask
	task automatic t_fill();
		// Full FIFO refuses, then drains with the reader stalling mid-packet
		push_pkt(2'h0, 16'h0a00, 32);
		chk1("in_ready full", 1'b0, in_ready);
		read_chan(5'h00, 5);
		check_words(16'h0a00, 32, 1);
		chk1("in_ready drained", 1'b1, in_ready);
	endtask
	task automatic t_cell();
		do_reset(rx_port_pkg::MODE_CELL);
		push_pkt(2'h0, 16'hc000, `RXP_CELL_WORDS);
		read_chan(5'h00, 99);
		check_words(16'hc000, `RXP_CELL_WORDS, 1);
	endtask
	task automatic t_byte();
		int n;
		do_reset(rx_port_pkg::MODE_BYTE);
		push_pkt(2'h3, 16'hb000, 2);
		n = 0;
		while (avail_direct !== 4'h8 && n < 100) begin
			@(posedge clk);
			#1 n++;
		end
		chk16("direct avail", 16'h0008, 16'(avail_direct));
		chk1("polled avail", 1'b0, avail_polled);
		read_chan(5'h03, 99);
		check_words(16'hb000, 2, 0);
		read_chan(5'h1f, 99);
		chk16("byte null words", 16'h0000, 16'(got_d.size()));
		chk16("direct empty", 16'h0000, 16'(avail_direct));
	endtask

	// ================================================================
	// Main sequence
	initial begin
		nrst = 0;
		mode = rx_port_pkg::MODE_PACKET;
		{in_valid, in_sop, in_eop, req_valid, user_stall} = 5'h00;
		in_chan = 2'h0;
		in_data = 16'h0000;
		req_chan = 5'h1f;
		t_packet();
		t_foreign();
		t_fill();
		t_cell();
		t_byte();
		end_of_test();
	end
endmodule

// ===== rx_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module rx_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Word storage
	logic [AW:0] wr_ptr; // Extra bit tells full from empty
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;

	// ================================================================
	// Flags
	assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
	assign out_valid = (wr_ptr != rd_ptr);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Head word shown without a read latency
	assign out_data = mem[rd_ptr[AW-1:0]];

	// Storage write; no reset needed for data
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// Write pointer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// Read pointer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// ===== rx_port_chk.sv
// Checker for the link between the receive read port and its controller.
// Assumes one clk domain; the link clock rises on a clk edge from the host.
`timescale 1ns/1ps
`include "rx_port_defs.svh"

module rx_port_chk (
	// Clock, reset and configuration
	input wire logic clk,
	input wire logic nrst,
	input rx_port_pkg::xfer_mode_e mode,
	// Link signals
	input wire logic link_clk,
	input wire logic rd_enb_n,
	input wire logic [`RXP_ADDR_W-1:0] rd_addr,
	input wire logic [`RXP_DATA_W-1:0] rx_data,
	input wire logic rx_data_oe,
	input wire logic rx_start_of_packet,
	input wire logic rx_sop_oe,
	input wire logic rx_data_valid,
	input wire logic rx_valid_oe,
	input wire logic rx_packet_available_polled,
	input wire logic [`RXP_DIRECT_W-1:0] rx_packet_available_direct
);
	// ================================================================
	// Device answers land a few clk after each link rise; ##5 leaves margin
	// for the input synchroniser yet stays before the next rise.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ================================================================
	// Assertions
	idle_enb_tri_a: assert property ($rose(link_clk) && rd_enb_n |-> ##5 !rx_sop_oe && !rx_data_oe)
		else $error("outputs driven after enable seen high");
	null_select_a: assert property ($rose(link_clk) && rd_enb_n && rd_addr >= `RXP_PORT_COUNT
		&& mode != rx_port_pkg::MODE_BYTE ##10 !rd_enb_n |-> ##5 !rx_sop_oe)
		else $error("start flag driven for a foreign address");
	byte_foreign_a: assert property ($rose(link_clk) && !rd_enb_n && rd_addr >= `RXP_PORT_COUNT
		&& mode == rx_port_pkg::MODE_BYTE |-> ##5 !rx_data_oe && !rx_data_valid)
		else $error("byte read answered a foreign address");
	sop_edge_a: assert property ($changed(rx_start_of_packet) || $changed(rx_sop_oe) |-> link_clk || $past(link_clk))
		else $error("start flag moved away from a link rise");
	word_hold_a: assert property ($rose(link_clk) |-> ##5 ($stable(rx_data) && $stable(rx_data_valid)) [*8])
		else $error("data changed between link rises");
	// Only a fresh selection (address came from null) starts a packet;
	// a resume after a controller pause lands mid-packet.
	first_sop_a: assert property ($rose(link_clk) && !rd_enb_n && $past(rd_enb_n, 10)
		&& $past(rd_addr, 20) == `RXP_NULL_ADDR
		&& mode == rx_port_pkg::MODE_PACKET ##5 rx_data_valid |-> rx_start_of_packet)
		else $error("first packet word lacks start flag");
	mid_sop_a: assert property ($rose(link_clk) && !rd_enb_n && !$past(rd_enb_n, 10)
		&& mode == rx_port_pkg::MODE_PACKET |-> ##5 !(rx_start_of_packet && rx_data_valid))
		else $error("start flag on a later packet word");
	valid_oe_mode_a: assert property ($rose(link_clk) |-> ##5 rx_valid_oe == (mode != rx_port_pkg::MODE_CELL))
		else $error("valid drive does not follow mode");
	byte_idle_a: assert property ($rose(link_clk) && rd_enb_n && mode == rx_port_pkg::MODE_BYTE |-> ##5 !rx_data_valid)
		else $error("byte mode moved data with enable high");
	direct_avail_a: assert property ($rose(link_clk) |-> ##5 (mode == rx_port_pkg::MODE_BYTE) ?
		!rx_packet_available_polled : rx_packet_available_direct == 4'h0)
		else $error("availability outputs wrong for mode");
endmodule

// ===== rx_port_defs.svh
// Constants shared by both ends of the receive read port.
// Assumes it is included by bare name from the modules and the interface.
`ifndef RX_PORT_DEFS_SVH
`define RX_PORT_DEFS_SVH

// ====================================================================
// Link layout
`define RXP_ADDR_W 5
`define RXP_NULL_ADDR 5'h1f
`define RXP_PORT_COUNT 5'h04
`define RXP_DATA_W 16
`define RXP_DIRECT_W 4

// ====================================================================
// Stored word layout: {end flag, start flag, data}
`define RXP_WORD_W 18
`define RXP_SOP_BIT 16
`define RXP_EOP_BIT 17
`define RXP_FIFO_DEPTH 32

// ====================================================================
// Timing: link clock made by the controller from clk
`define RXP_CLK_NS 5
`define RXP_LINK_NS 50
`define RXP_LINK_HALF (`RXP_LINK_NS / `RXP_CLK_NS / 2)
`define RXP_CELL_WORDS 6'h1b

`endif

// ===== rx_port_device.sv
// Receive read port of a four-channel device: per-channel FIFOs
// drained by an external controller over the link.
// Assumes the link clock comes from the controller and is sampled here.
`timescale 1ns/1ps
`include "rx_port_defs.svh"

module rx_port_device (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Configuration, held constant while running
	input rx_port_pkg::xfer_mode_e mode,
	// Word source feeding the channel FIFOs
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [1:0] in_chan,
	input wire logic [`RXP_DATA_W-1:0] in_data,
	input wire logic in_sop,
	input wire logic in_eop,
	// Link to the controller
	rx_port_if.device link
);
	// ================================================================
	// Declarations
	logic [6:0] pin_s1; // First stage, read only by pin_s2
	logic [6:0] pin_s2;
	logic [6:0] pin_s3;
	logic link_lvl; // Settled level of the link clock
	logic link_edge; // One-cycle pulse per link rising edge
	logic enb_n; // Sampled read enable, active low
	logic [`RXP_ADDR_W-1:0] addr; // Sampled read address
	logic [`RXP_ADDR_W-1:0] sel; // Latched channel address
	logic done; // Packet ended, wait for reselection
	logic [`RXP_ADDR_W-1:0] rd_chan; // Channel used this edge
	logic drive; // Outputs driven this edge
	logic word_ok; // A word is taken from a FIFO this edge
	logic [3:0] fifo_in_ready;
	logic [3:0] fifo_valid;
	logic [3:0] pop;
	logic [3:0] avail; // Packet available per channel
	logic [`RXP_WORD_W-1:0] fifo_word [4];
	logic [`RXP_WORD_W-1:0] head; // Head word of rd_chan
	logic [5:0] eop_cnt [4]; // Whole packets held per channel

	// Address hits one of our own ports; null is above the range
	function automatic logic port_hit(input logic [`RXP_ADDR_W-1:0] a);
		port_hit = (a < `RXP_PORT_COUNT);
	endfunction

	// ================================================================
	// Link input sampling
	// Clock, enable and address share one pipeline so that the values
	// seen at an edge are the ones that stood at that edge.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pin_s1 <= 7'h00;
			pin_s2 <= 7'h00;
			pin_s3 <= 7'h00;
		end else begin
			pin_s1 <= {link.link_clk, link.rd_enb_n, link.rd_addr};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// Link clock level counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!nrst) begin
			link_lvl <= 1'b0;
		end else if (pin_s2[6] == pin_s3[6]) begin
			link_lvl <= pin_s3[6];
		end
	end

	assign link_edge = (pin_s2[6] == pin_s3[6]) && pin_s3[6] && !link_lvl;
	assign enb_n = pin_s3[5];
	assign addr = pin_s3[4:0];

	// ================================================================
	// Channel FIFOs
	// A FIFO that fills stalls the source through in_ready; overflow
	// protection otherwise relies on the controller reading in time.
	assign in_ready = fifo_in_ready[in_chan];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_chan
			logic push_eop;
			logic pop_eop;

			rx_fifo #(
				.WIDTH(`RXP_WORD_W),
				.DEPTH(`RXP_FIFO_DEPTH)
			) u_fifo (
				.clk(clk),
				.nrst(nrst),
				.in_valid(in_valid && (in_chan == 2'(g))),
				.in_ready(fifo_in_ready[g]),
				.in_data({in_eop, in_sop, in_data}),
				.out_valid(fifo_valid[g]),
				.out_ready(pop[g]),
				.out_data(fifo_word[g])
			);

			assign push_eop = in_valid && fifo_in_ready[g] && (in_chan == 2'(g)) && in_eop;
			assign pop_eop = pop[g] && fifo_word[g][`RXP_EOP_BIT];

			// Count complete packets; a full FIFO also counts as available
			always_ff @(posedge clk) begin
				if (!nrst) begin
					eop_cnt[g] <= 6'h00;
				end else begin
					case ({push_eop, pop_eop})
						2'b10: eop_cnt[g] <= eop_cnt[g] + 6'h01;
						2'b01: eop_cnt[g] <= eop_cnt[g] - 6'h01;
						default: eop_cnt[g] <= eop_cnt[g];
					endcase
				end
			end

			assign avail[g] = (eop_cnt[g] != 6'h00) || !fifo_in_ready[g];
			assign pop[g] = link_edge && word_ok && (rd_chan[1:0] == 2'(g));
		end
	endgenerate

	// ================================================================
	// Read decision for the current edge
	// The mode input is not latched and is also read by the selection,
	// done, valid and availability blocks; changing it while running is not supported.
	always_comb begin
		rd_chan = sel;
		drive = 1'b0;
		word_ok = 1'b0;
		case (mode)
			rx_port_pkg::MODE_CELL: begin
				// Enable low reads the latched channel
				drive = !enb_n && port_hit(sel);
				word_ok = drive;
			end
			rx_port_pkg::MODE_PACKET: begin
				// Channel fixed during transfer; address only polls
				drive = !enb_n && port_hit(sel);
				word_ok = drive && !done;
			end
			rx_port_pkg::MODE_BYTE: begin
				// Channel taken from the address of this very edge
				rd_chan = addr;
				drive = !enb_n && port_hit(addr);
				word_ok = drive;
			end
			default: begin
				drive = 1'b0;
			end
		endcase
		head = fifo_word[rd_chan[1:0]];
		// An empty FIFO gives no word
		word_ok = word_ok && fifo_valid[rd_chan[1:0]];
	end

	// ================================================================
	// Channel selection
	// Latched only while enable is high, so a paused transfer keeps
	// its channel when the controller holds the same address.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sel <= `RXP_NULL_ADDR;
		end else if (link_edge && enb_n && (mode != rx_port_pkg::MODE_BYTE)) begin
			sel <= addr;
		end
	end

	// End of packet blocks further words until a new selection phase
	always_ff @(posedge clk) begin
		if (!nrst) begin
			done <= 1'b0;
		end else if (link_edge) begin
			if (enb_n) begin
				done <= 1'b0;
			end else if (word_ok && head[`RXP_EOP_BIT] && (mode == rx_port_pkg::MODE_PACKET)) begin
				done <= 1'b1;
			end
		end
	end

	// ================================================================
	// Data, start flag and enables, updated on link edges only
	always_ff @(posedge clk) begin
		if (!nrst) begin
			link.rx_data <= 16'h0000;
			link.rx_data_oe <= 1'b0;
			link.rx_start_of_packet <= 1'b0;
			link.rx_sop_oe <= 1'b0;
		end else if (link_edge) begin
			// Tristate on enable high or on an address not ours
			link.rx_data_oe <= drive;
			link.rx_sop_oe <= drive;
			if (word_ok) begin
				link.rx_data <= head[`RXP_DATA_W-1:0];
			end
			// Set only with the first word of each packet
			link.rx_start_of_packet <= word_ok && head[`RXP_SOP_BIT];
		end
	end

	// Valid flag: driven in packet modes, tristated in cell mode
	always_ff @(posedge clk) begin
		if (!nrst) begin
			link.rx_data_valid <= 1'b0;
			link.rx_valid_oe <= 1'b0;
		end else if (link_edge) begin
			link.rx_valid_oe <= (mode != rx_port_pkg::MODE_CELL);
			link.rx_data_valid <= word_ok && (mode != rx_port_pkg::MODE_CELL);
		end
	end

	// ================================================================
	// Availability: polled by address, or direct in byte level mode
	always_ff @(posedge clk) begin
		if (!nrst) begin
			link.rx_packet_available_polled <= 1'b0;
			link.rx_packet_available_direct <= 4'h0;
		end else if (link_edge) begin
			// Polling answers in every phase, never for null
			link.rx_packet_available_polled <= (mode != rx_port_pkg::MODE_BYTE) && port_hit(addr)
				&& avail[addr[1:0]];
			if (mode == rx_port_pkg::MODE_BYTE) begin
				link.rx_packet_available_direct <= avail;
			end else begin
				link.rx_packet_available_direct <= 4'h0;
			end
		end
	end
endmodule

// ===== rx_port_host.sv
// Controller end of the receive read port: makes the link clock,
// selects channels and drains words into a plain word stream.
// Assumes the device updates its outputs within a link half period.
`timescale 1ns/1ps
`include "rx_port_defs.svh"

module rx_port_host (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Configuration, same mode as the device
	input rx_port_pkg::xfer_mode_e mode,
	// Read requests
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [`RXP_ADDR_W-1:0] req_chan,
	// Received words
	input wire logic user_stall,
	output logic word_valid,
	output logic [`RXP_DATA_W-1:0] word_data,
	output logic word_sop,
	// Availability seen on the link
	output logic avail_polled,
	output logic [`RXP_DIRECT_W-1:0] avail_direct,
	// Link to the device
	rx_port_if.host link
);
	// ================================================================
	// Declarations
	rx_port_pkg::host_state_e state;
	logic [3:0] div_cnt; // Half period counter
	logic rise_tick; // Link clock goes high now
	logic fall_tick; // Link clock goes low now
	logic [25:0] in_s1; // First stage, read only by in_s2
	logic [25:0] in_s2;
	logic [25:0] in_s3;
	logic s_data_oe;
	logic [`RXP_DATA_W-1:0] s_data;
	logic s_sop;
	logic s_valid;
	logic s_polled;
	logic rd_prev; // Enable was low at the previous rise
	logic ended; // Valid dropped after a read
	logic [5:0] issued; // Reads issued this transfer in any mode; only cell mode uses the count
	logic got_word;

	// ================================================================
	// Link clock divider
	assign rise_tick = (div_cnt == 4'(`RXP_LINK_HALF - 1)) && !link.link_clk;
	assign fall_tick = (div_cnt == 4'(`RXP_LINK_HALF - 1)) && link.link_clk;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			div_cnt <= 4'h0;
			link.link_clk <= 1'b0;
		end else if (div_cnt == 4'(`RXP_LINK_HALF - 1)) begin
			div_cnt <= 4'h0;
			link.link_clk <= !link.link_clk;
		end else begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// ================================================================
	// Device outputs pass three flip-flops; only the third is used
	always_ff @(posedge clk) begin
		if (!nrst) begin
			in_s1 <= 26'h0000000;
			in_s2 <= 26'h0000000;
			in_s3 <= 26'h0000000;
		end else begin
			in_s1 <= {link.rx_data_oe, link.rx_data, link.rx_sop_oe && link.rx_start_of_packet,
				link.rx_valid_oe && link.rx_data_valid, link.rx_packet_available_polled,
				link.rx_packet_available_direct, 2'h0};
			in_s2 <= in_s1;
			in_s3 <= in_s2;
		end
	end

	assign s_data_oe = in_s3[25];
	assign s_data = in_s3[24:9];
	assign s_sop = in_s3[8];
	assign s_valid = in_s3[7];
	assign s_polled = in_s3[6];
	// Cell mode has no valid flag, so a driven bus marks a word
	assign got_word = rd_prev && ((mode == rx_port_pkg::MODE_CELL) ? s_data_oe : s_valid);
	assign req_ready = (state == rx_port_pkg::HOST_IDLE);

	// ================================================================
	// Sampling at link rise: words, pending reads and end detection
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_prev <= 1'b0;
			ended <= 1'b0;
			issued <= 6'h00;
		end else if (rise_tick) begin
			rd_prev <= !link.rd_enb_n;
			if (state == rx_port_pkg::HOST_IDLE) begin
				ended <= 1'b0;
				issued <= 6'h00;
			end else begin
				if (rd_prev && !got_word && (mode != rx_port_pkg::MODE_CELL)) begin
					ended <= 1'b1;
				end
				if (!link.rd_enb_n) begin
					issued <= issued + 6'h01;
				end
			end
		end
	end

	// Word stream and availability, one-cycle word pulse
	always_ff @(posedge clk) begin
		if (!nrst) begin
			word_valid <= 1'b0;
			word_data <= 16'h0000;
			word_sop <= 1'b0;
			avail_polled <= 1'b0;
			avail_direct <= 4'h0;
		end else begin
			word_valid <= rise_tick && got_word;
			if (rise_tick) begin
				avail_polled <= s_polled;
				avail_direct <= in_s3[5:2];
				if (got_word) begin
					word_data <= s_data;
					word_sop <= s_sop;
				end
			end
		end
	end

	// ================================================================
	// Sequencer; enable and address change at link fall, stable at rise
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= rx_port_pkg::HOST_IDLE;
			link.rd_enb_n <= 1'b1;
			link.rd_addr <= `RXP_NULL_ADDR;
		end else if (fall_tick) begin
			case (state)
				rx_port_pkg::HOST_IDLE: begin
					link.rd_enb_n <= 1'b1;
					if (req_valid) begin
						link.rd_addr <= req_chan;
						state <= rx_port_pkg::HOST_SELECT;
					end else begin
						link.rd_addr <= `RXP_NULL_ADDR;
					end
				end
				rx_port_pkg::HOST_SELECT: begin
					// Cell mode waits until a whole cell is polled available
					if ((mode != rx_port_pkg::MODE_CELL) || s_polled) begin
						link.rd_enb_n <= user_stall;
						state <= rx_port_pkg::HOST_XFER;
					end
				end
				rx_port_pkg::HOST_XFER: begin
					if (ended || ((mode == rx_port_pkg::MODE_CELL) && (issued == `RXP_CELL_WORDS) && !rd_prev)) begin
						link.rd_enb_n <= 1'b1;
						link.rd_addr <= `RXP_NULL_ADDR;
						state <= rx_port_pkg::HOST_IDLE;
					end else begin
						// Pause by raising enable, address kept
						link.rd_enb_n <= user_stall || ended
							|| ((mode == rx_port_pkg::MODE_CELL) && (issued == `RXP_CELL_WORDS));
					end
				end
				default: begin
					state <= rx_port_pkg::HOST_IDLE;
				end
			endcase
		end
	end
endmodule

// ===== rx_port_if.sv
// Link between the receive read port and its controller.
// Assumes the bench resolves shared wires from the enables.
`timescale 1ns/1ps
`include "rx_port_defs.svh"

interface rx_port_if;
	// Controller to device
	logic link_clk;
	logic rd_enb_n;
	logic [`RXP_ADDR_W-1:0] rd_addr;
	// Device to controller; data, start flag and valid each with its drive enable
	logic [`RXP_DATA_W-1:0] rx_data;
	logic rx_data_oe;
	logic rx_start_of_packet;
	logic rx_sop_oe;
	logic rx_data_valid;
	logic rx_valid_oe;
	logic rx_packet_available_polled;
	logic [`RXP_DIRECT_W-1:0] rx_packet_available_direct;

	modport device (
		input link_clk, rd_enb_n, rd_addr,
		output rx_data, rx_data_oe, rx_start_of_packet, rx_sop_oe,
		output rx_data_valid, rx_valid_oe,
		output rx_packet_available_polled, rx_packet_available_direct
	);

	modport host (
		output link_clk, rd_enb_n, rd_addr,
		input rx_data, rx_data_oe, rx_start_of_packet, rx_sop_oe,
		input rx_data_valid, rx_valid_oe,
		input rx_packet_available_polled, rx_packet_available_direct
	);
endinterface

// ===== rx_port_pkg.sv
// Types shared by both ends of the receive read port.
// Assumes rx_port_defs.svh is on the include path.
package rx_port_pkg;

	// ================================================================
	// Transfer mode, fixed by configuration while running
	typedef enum logic [1:0] {
		MODE_CELL,
		MODE_PACKET,
		MODE_BYTE
	} xfer_mode_e;

	// ================================================================
	// Controller sequencing
	typedef enum logic [1:0] {
		HOST_IDLE,
		HOST_SELECT,
		HOST_XFER
	} host_state_e;

endpackage
